// ### sfpm_consts.svh
// constants for the servo front-panel monitor
//
// Contract
// RULE1: In the I/O view each digit lights its upper half for an asserted signal, else its lower half.
// RULE2: In the I/O view a lit decimal point marks an input digit and an unlit one an output digit.
// RULE3: Inputs and outputs are shown ten each with the lowest-numbered signal rightmost.
// RULE4: The single-turn count of the 23-bit encoder runs from 0 to 8388607.
// RULE5: Counter-clockwise motion raises the position count and clockwise motion lowers it.
// RULE6: A single-turn wrap past 8388607 adds one turn and a wrap below 0 takes one away.
// RULE7: The multiturn count is signed 16-bit and wraps between 32767 and -32768 both ways.
// RULE8: The power-on selector takes 0 to 42, defaults to 34 and acts only after a restart.
// RULE9: The selector picks the power-on view among the listed monitored quantities.
// RULE10: The no-rotation view reports the numbered cause codes 1 to 10, 12 and 13.
// RULE11: Code 3 is given for overtravel setting 0 with a limit open against the command sign.
// RULE12: Code 9 is given for clamp setting 1 with the zero-speed clamp input open.
// RULE13: The servo status view shows state machine, bus state, running mode and condition.
// RULE14: The high half of a wide value lights the two rightmost points, the low half none.
// RULE15: A negative value lights the two leftmost points, a positive value leaves them dark.
// RULE16: A selector write outside 0 to 42 leaves the stored value unchanged.
// RULE17: A multiturn step happens in the same cycle as the single-turn wrap causing it.
`ifndef SFPM_CONSTS_SVH
`define SFPM_CONSTS_SVH

`define SFPM_SEL_INDEX 16'h2528
`define SFPM_SEL_RESET 16'h0022
`define SFPM_SEL_MAX 16'h002A
`define SFPM_ST_MAX 23'h7F_FFFF

`define SFPM_V_POSDEV 6'h00
`define SFPM_V_SPEED 6'h01
`define SFPM_V_CTRL 6'h09
`define SFPM_V_IO 6'h0A
`define SFPM_V_ERR 6'h0C
`define SFPM_V_NOROT 6'h11
`define SFPM_V_ST 6'h15
`define SFPM_V_MT 6'h16
`define SFPM_V_SERVO 6'h22
`define SFPM_V_ODIDX 6'h29
`define SFPM_V_ODVAL 6'h2A

`define SFPM_CP_UNDERVOLT 4'h1
`define SFPM_CP_NOSERVO 4'h2
`define SFPM_CP_OVERTRAVEL 4'h3
`define SFPM_CP_ALARM 4'h4
`define SFPM_CP_RELAY 4'h5
`define SFPM_CP_ESTOP 4'h6
`define SFPM_CP_POSLOW 4'h7
`define SFPM_CP_TQLIM 4'h8
`define SFPM_CP_CLAMP 4'h9
`define SFPM_CP_SPDLOW 4'hA
`define SFPM_CP_TQLOW 4'hC
`define SFPM_CP_BUSESTOP 4'hD

`define SFPM_OT_ACTIVE 16'h0000
`define SFPM_CLAMP_ACTIVE 16'h0001

`define SFPM_DP_HIGH 10'h003
`define SFPM_DP_NEG 10'h300
`define SFPM_DP_ALL 10'h3FF

`endif

// ### sfpm_pkg.sv
// types of the servo front-panel monitor
package sfpm_pkg;

    typedef struct packed {
        logic [5:0] view;
        logic [15:0] value;
        logic [9:0] dp;
        logic [9:0] upper;
        logic [9:0] lower;
    } sfpm_disp_t;

    typedef struct packed {
        logic [15:0] sel_stored;
        logic [5:0] sel_active;
        logic [22:0] single_turn;
        logic [15:0] multiturn;
        logic high_half;
        logic io_out_page;
        logic [3:0] no_rotation_code;
        logic [15:0] rdata;
        sfpm_disp_t disp;
    } sfpm_state_t;

endpackage : sfpm_pkg

// ### sfpm_monitor.sv
// front-panel monitor: view select, I/O encoding, encoder counts, no-rotation cause
`timescale 1ns/1ps
`include "sfpm_consts.svh"

module sfpm_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic restart_i,
    input wire logic param_wr_i,
    input wire logic param_rd_i,
    input wire logic [15:0] param_index_i,
    input wire logic [15:0] param_wdata_i,
    output logic [15:0] param_rdata_o,
    input wire logic enc_step_i,
    input wire logic enc_ccw_i,
    input wire logic half_toggle_i,
    input wire logic io_page_toggle_i,
    input wire logic [9:0] digital_input_i,
    input wire logic [9:0] digital_output_i,
    input wire logic [31:0] pos_dev_i,
    input wire logic [15:0] motor_speed_i,
    input wire logic [7:0] control_mode_i,
    input wire logic [15:0] error_record_i,
    input wire logic [23:0] od_index_i,
    input wire logic [31:0] od_value_i,
    input wire logic [3:0] fsm_state_i,
    input wire logic [3:0] bus_state_i,
    input wire logic [3:0] run_mode_i,
    input wire logic running_i,
    input wire logic bus_undervolt_i,
    input wire logic servo_on_input_i,
    input wire logic [15:0] overtravel_setting_i,
    input wire logic positive_limit_open_i,
    input wire logic negative_limit_open_i,
    input wire logic [15:0] speed_cmd_i,
    input wire logic drive_alarm_i,
    input wire logic relay_open_i,
    input wire logic estop_i,
    input wire logic pos_cmd_low_i,
    input wire logic torque_limited_i,
    input wire logic [15:0] zero_speed_clamp_setting_i,
    input wire logic zero_speed_clamp_open_i,
    input wire logic speed_cmd_low_i,
    input wire logic torque_cmd_low_i,
    input wire logic bus_estop_i,
    output sfpm_pkg::sfpm_disp_t disp_o,
    output logic [22:0] single_turn_o,
    output logic [15:0] multiturn_o,
    output logic [3:0] no_rotation_code_o
);

    localparam sfpm_pkg::sfpm_state_t RESET_STATE = '{
        sel_stored: `SFPM_SEL_RESET,
        sel_active: `SFPM_V_SERVO,
        single_turn: 23'h00_0000,
        multiturn: 16'h0000,
        high_half: 1'b0,
        io_out_page: 1'b0,
        no_rotation_code: 4'h0,
        rdata: 16'h0000,
        disp: '0
    };

    sfpm_pkg::sfpm_state_t s;
    sfpm_pkg::sfpm_state_t next_s;
    logic [3:0] cause;
    logic ot_block;
    logic [31:0] wide;
    logic [31:0] mag;
    logic neg;
    logic signed_view;
    logic sel_hit;

    assign sel_hit = (param_index_i == `SFPM_SEL_INDEX);

    // RULE11 overtravel against command
    assign ot_block = (overtravel_setting_i == `SFPM_OT_ACTIVE) &&
        ((positive_limit_open_i && !speed_cmd_i[15] && (speed_cmd_i != 16'h0000)) ||
         (negative_limit_open_i && speed_cmd_i[15]));

    // RULE10 lowest code wins
    always_comb begin
        if (bus_undervolt_i) begin
            cause = `SFPM_CP_UNDERVOLT;
        end else if (!servo_on_input_i) begin
            cause = `SFPM_CP_NOSERVO;
        end else if (ot_block) begin
            cause = `SFPM_CP_OVERTRAVEL;
        end else if (drive_alarm_i) begin
            cause = `SFPM_CP_ALARM;
        end else if (relay_open_i) begin
            cause = `SFPM_CP_RELAY;
        end else if (estop_i) begin
            cause = `SFPM_CP_ESTOP;
        end else if (pos_cmd_low_i) begin
            cause = `SFPM_CP_POSLOW;
        end else if (torque_limited_i) begin
            cause = `SFPM_CP_TQLIM;
        // RULE12 zero-speed clamp
        end else if ((zero_speed_clamp_setting_i == `SFPM_CLAMP_ACTIVE) &&
                     zero_speed_clamp_open_i) begin
            cause = `SFPM_CP_CLAMP;
        end else if (speed_cmd_low_i) begin
            cause = `SFPM_CP_SPDLOW;
        end else if (torque_cmd_low_i) begin
            cause = `SFPM_CP_TQLOW;
        end else if (bus_estop_i) begin
            cause = `SFPM_CP_BUSESTOP;
        end else begin
            cause = 4'h0;
        end
    end

    // RULE9 power-on view source
    always_comb begin
        wide = 32'h0000_0000;
        signed_view = 1'b0;
        unique case (s.sel_active)
            `SFPM_V_POSDEV: begin
                wide = pos_dev_i;
                signed_view = 1'b1;
            end
            `SFPM_V_SPEED: begin
                wide = {{16{motor_speed_i[15]}}, motor_speed_i};
                signed_view = 1'b1;
            end
            `SFPM_V_CTRL: wide = {24'h00_0000, control_mode_i};
            `SFPM_V_ERR: wide = {16'h0000, error_record_i};
            `SFPM_V_NOROT: wide = {28'h000_0000, s.no_rotation_code};
            `SFPM_V_ST: wide = {9'h000, s.single_turn};
            `SFPM_V_MT: begin
                wide = {{16{s.multiturn[15]}}, s.multiturn};
                signed_view = 1'b1;
            end
            // RULE13 servo status fields
            `SFPM_V_SERVO: wide = {19'h0_0000, fsm_state_i, bus_state_i, run_mode_i, running_i};
            `SFPM_V_ODIDX: wide = {8'h00, od_index_i};
            `SFPM_V_ODVAL: wide = od_value_i;
            default: wide = 32'h0000_0000;
        endcase
        neg = signed_view && wide[31];
        mag = neg ? 32'(32'h0000_0000 - wide) : wide;
    end

    always_comb begin
        next_s = s;
        // RULE16 out-of-range write ignored
        if (param_wr_i && sel_hit && (param_wdata_i <= `SFPM_SEL_MAX)) begin
            next_s.sel_stored = param_wdata_i;
        end
        next_s.rdata = (param_rd_i && sel_hit) ? s.sel_stored : 16'h0000;
        // RULE8 selector acts on restart
        if (restart_i) begin
            next_s.sel_active = s.sel_stored[5:0];
            next_s.high_half = 1'b0;
            next_s.io_out_page = 1'b0;
        end else begin
            next_s.high_half = s.high_half ^ half_toggle_i;
            next_s.io_out_page = s.io_out_page ^ io_page_toggle_i;
        end
        // RULE5 direction of count
        if (enc_step_i && enc_ccw_i) begin
            // RULE6 wrap up adds a turn
            if (s.single_turn == `SFPM_ST_MAX) begin
                next_s.single_turn = 23'h00_0000;
                // RULE7 16-bit two's complement wrap
                next_s.multiturn = 16'(s.multiturn + 16'h0001);
            end else begin
                next_s.single_turn = 23'(s.single_turn + 23'h00_0001);
            end
        end else if (enc_step_i) begin
            // RULE4 stays within one revolution
            if (s.single_turn == 23'h00_0000) begin
                next_s.single_turn = `SFPM_ST_MAX;
                // RULE17 same-cycle turn step
                next_s.multiturn = 16'(s.multiturn - 16'h0001);
            end else begin
                next_s.single_turn = 23'(s.single_turn - 23'h00_0001);
            end
        end
        next_s.no_rotation_code = cause;
        next_s.disp.view = s.sel_active;
        if (s.sel_active == `SFPM_V_IO) begin
            // RULE1 upper half means asserted
            // RULE3 bit 0 on rightmost digit
            next_s.disp.upper = s.io_out_page ? digital_output_i : digital_input_i;
            next_s.disp.lower = ~next_s.disp.upper;
            // RULE2 points mark the input page
            next_s.disp.dp = s.io_out_page ? 10'h000 : `SFPM_DP_ALL;
            next_s.disp.value = 16'h0000;
        end else begin
            next_s.disp.upper = 10'h000;
            next_s.disp.lower = 10'h000;
            // RULE14 half marker
            // RULE15 sign marker
            next_s.disp.dp = (s.high_half ? `SFPM_DP_HIGH : 10'h000) |
                             (neg ? `SFPM_DP_NEG : 10'h000);
            next_s.disp.value = s.high_half ? mag[31:16] : mag[15:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign param_rdata_o = s.rdata;
    assign disp_o = s.disp;
    assign single_turn_o = s.single_turn;
    assign multiturn_o = s.multiturn;
    assign no_rotation_code_o = s.no_rotation_code;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_in_page;
        (s.sel_active == `SFPM_V_IO) && !s.io_out_page && !restart_i;
    endsequence

    property p_io_upper;
        s_in_page |=> (disp_o.upper == $past(digital_input_i)) && (disp_o.lower == ~disp_o.upper);
    endproperty
    a_io_upper: assert property (p_io_upper) else $error("io halves wrong"); // RULE1

    property p_io_dp;
        (s.sel_active == `SFPM_V_IO) && !restart_i |=>
            (disp_o.dp == ($past(s.io_out_page) ? 10'h000 : `SFPM_DP_ALL));
    endproperty
    a_io_dp: assert property (p_io_dp) else $error("io point wrong"); // RULE2

    property p_io_out;
        (s.sel_active == `SFPM_V_IO) && s.io_out_page && !restart_i |=>
            disp_o.upper == $past(digital_output_i);
    endproperty
    a_io_out: assert property (p_io_out) else $error("output order wrong"); // RULE3

    property p_st_range;
        single_turn_o <= `SFPM_ST_MAX;
    endproperty
    a_st_range: assert property (p_st_range) else $error("single turn out of range"); // RULE4

    property p_ccw_up;
        enc_step_i && enc_ccw_i && (single_turn_o != `SFPM_ST_MAX) |=>
            (single_turn_o == 23'($past(single_turn_o) + 23'h00_0001)) && $stable(multiturn_o);
    endproperty
    a_ccw_up: assert property (p_ccw_up) else $error("ccw step wrong"); // RULE5

    sequence s_wrap_up;
        enc_step_i && enc_ccw_i && (single_turn_o == `SFPM_ST_MAX);
    endsequence

    property p_wrap_up;
        s_wrap_up |=> (single_turn_o == 23'h00_0000) &&
            (multiturn_o == 16'($past(multiturn_o) + 16'h0001));
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("upward wrap wrong"); // RULE6

    property p_mt_wrap;
        enc_step_i && !enc_ccw_i && (single_turn_o == 23'h00_0000) &&
            (multiturn_o == 16'h8000) |=> (multiturn_o == 16'h7FFF) &&
            (single_turn_o == `SFPM_ST_MAX);
    endproperty
    a_mt_wrap: assert property (p_mt_wrap) else $error("multiturn wrap wrong"); // RULE7

    property p_sel_defer;
        !restart_i |=> $stable(s.sel_active);
    endproperty
    a_sel_defer: assert property (p_sel_defer) else $error("view changed without restart"); // RULE8

    property p_sel_range;
        param_wr_i && sel_hit && (param_wdata_i > `SFPM_SEL_MAX) |=> $stable(s.sel_stored);
    endproperty
    a_sel_range: assert property (p_sel_range) else $error("bad selector stored"); // RULE16

    property p_ot_code;
        !bus_undervolt_i && servo_on_input_i && ot_block |=>
            no_rotation_code_o == `SFPM_CP_OVERTRAVEL;
    endproperty
    a_ot_code: assert property (p_ot_code) else $error("overtravel code missing"); // RULE11

    property p_half_dp;
        (s.sel_active != `SFPM_V_IO) && !restart_i |=>
            (disp_o.dp[1:0] == {2{$past(s.high_half)}});
    endproperty
    a_half_dp: assert property (p_half_dp) else $error("half marker wrong"); // RULE14

endmodule : sfpm_monitor

// ### sfpm_panel_model.sv
// front-panel display model: flags digit patterns the panel cannot show
`timescale 1ns/1ps
`include "sfpm_consts.svh"

module sfpm_panel_model (
    input wire logic clk_i,
    input wire sfpm_pkg::sfpm_disp_t disp_i,
    output logic io_ok_o
);
    // one half per digit
    // a digit with both halves lit, or neither, reads as garbage on the tube
    always_ff @(posedge clk_i) begin
        io_ok_o <= (disp_i.view != `SFPM_V_IO) || ((disp_i.upper ^ disp_i.lower) == `SFPM_DP_ALL);
    end
endmodule : sfpm_panel_model

// ### servo_front_panel_monitor_bench.sv
// self-checking bench of the servo front-panel monitor
`timescale 1ns/1ps
`include "sfpm_consts.svh"

module servo_front_panel_monitor_bench;
    logic clk_i, rst_i, restart_i, param_wr_i, param_rd_i, enc_step_i, enc_ccw_i, running_i;
    logic half_toggle_i, io_page_toggle_i, bus_undervolt_i, servo_on_input_i, estop_i;
    logic positive_limit_open_i, negative_limit_open_i, drive_alarm_i, relay_open_i, io_ok;
    logic pos_cmd_low_i, torque_limited_i, zero_speed_clamp_open_i, speed_cmd_low_i;
    logic torque_cmd_low_i, bus_estop_i;
    logic [15:0] param_index_i, param_wdata_i, param_rdata_o, motor_speed_i, error_record_i;
    logic [15:0] overtravel_setting_i, speed_cmd_i, zero_speed_clamp_setting_i, multiturn_o;
    logic [9:0] digital_input_i, digital_output_i;
    logic [31:0] pos_dev_i, od_value_i, e, r;
    logic [7:0] control_mode_i;
    logic [23:0] od_index_i;
    logic [3:0] fsm_state_i, bus_state_i, run_mode_i, no_rotation_code_o;
    logic [22:0] single_turn_o, exp_st;
    logic [15:0] exp_mt;
    logic [5:0] views [0:9];
    sfpm_pkg::sfpm_disp_t disp_o;
    integer seed, n_mismatch, n_compared, i, k;

    sfpm_monitor u_sfpm_monitor (.clk_i, .rst_i, .restart_i, .param_wr_i, .param_rd_i,
        .param_index_i, .param_wdata_i, .param_rdata_o, .enc_step_i, .enc_ccw_i,
        .half_toggle_i, .io_page_toggle_i, .digital_input_i, .digital_output_i, .pos_dev_i,
        .motor_speed_i, .control_mode_i, .error_record_i, .od_index_i, .od_value_i,
        .fsm_state_i, .bus_state_i, .run_mode_i, .running_i, .bus_undervolt_i,
        .servo_on_input_i, .overtravel_setting_i, .positive_limit_open_i,
        .negative_limit_open_i, .speed_cmd_i, .drive_alarm_i, .relay_open_i, .estop_i,
        .pos_cmd_low_i, .torque_limited_i, .zero_speed_clamp_setting_i,
        .zero_speed_clamp_open_i, .speed_cmd_low_i, .torque_cmd_low_i, .bus_estop_i,
        .disp_o, .single_turn_o, .multiturn_o, .no_rotation_code_o);
    sfpm_panel_model u_sfpm_panel_model (.clk_i(clk_i), .disp_i(disp_o), .io_ok_o(io_ok));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    task automatic param(input logic wr, input logic [15:0] idx, input logic [15:0] d);
        @(posedge clk_i);
        param_wr_i <= wr;
        param_rd_i <= !wr;
        param_index_i <= idx;
        param_wdata_i <= d;
        @(posedge clk_i);
        param_wr_i <= 1'b0;
        param_rd_i <= 1'b0;
        #1;
    endtask : param

    // one-cycle pulse on a toggle or restart line, then let the display settle
    task automatic pulse(input integer which);
        @(posedge clk_i);
        if (which == 0) restart_i <= 1'b1;
        if (which == 1) half_toggle_i <= 1'b1;
        if (which == 2) io_page_toggle_i <= 1'b1;
        @(posedge clk_i);
        {restart_i, half_toggle_i, io_page_toggle_i} <= 3'b000;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : pulse

    task automatic step(input logic ccw);
        @(posedge clk_i);
        enc_step_i <= 1'b1;
        enc_ccw_i <= ccw;
        @(posedge clk_i);
        enc_step_i <= 1'b0;
        #1;
        if (ccw && exp_st == `SFPM_ST_MAX) exp_mt = exp_mt + 16'h0001;
        if (!ccw && exp_st == 23'h0) exp_mt = exp_mt - 16'h0001;
        exp_st = ccw ? exp_st + 23'h1 : exp_st - 23'h1;
        check(single_turn_o, exp_st);
        check(multiturn_o, exp_mt);
    endtask : step

    function automatic logic [31:0] mag(input logic [31:0] x);
        return x[31] ? -x : x;
    endfunction : mag

    function automatic logic [31:0] src(input logic [5:0] v);
        case (v)
            `SFPM_V_POSDEV: return mag(pos_dev_i);
            `SFPM_V_SPEED: return mag({{16{motor_speed_i[15]}}, motor_speed_i});
            `SFPM_V_CTRL: return {24'h0000_00, control_mode_i};
            `SFPM_V_ERR: return {16'h0000, error_record_i};
            `SFPM_V_ST: return {9'h000, exp_st};
            `SFPM_V_MT: return mag({{16{exp_mt[15]}}, exp_mt});
            `SFPM_V_SERVO: return {19'h0_0000, fsm_state_i, bus_state_i, run_mode_i, running_i};
            `SFPM_V_ODIDX: return {8'h00, od_index_i};
            `SFPM_V_ODVAL: return od_value_i;
            default: return 32'h0000_0000;
        endcase
    endfunction : src

    function automatic logic neg(input logic [5:0] v);
        return (v == `SFPM_V_POSDEV && pos_dev_i[31]) || (v == `SFPM_V_MT && exp_mt[15])
            || (v == `SFPM_V_SPEED && motor_speed_i[15]);
    endfunction : neg

    // lowest code number wins when several causes hold
    function automatic logic [3:0] exp_code();
        if (bus_undervolt_i) return `SFPM_CP_UNDERVOLT;
        if (!servo_on_input_i) return `SFPM_CP_NOSERVO;
        if (overtravel_setting_i == `SFPM_OT_ACTIVE && ((positive_limit_open_i
            && !speed_cmd_i[15] && speed_cmd_i != 16'h0000)
            || (negative_limit_open_i && speed_cmd_i[15]))) return `SFPM_CP_OVERTRAVEL;
        if (drive_alarm_i) return `SFPM_CP_ALARM;
        if (relay_open_i) return `SFPM_CP_RELAY;
        if (estop_i) return `SFPM_CP_ESTOP;
        if (pos_cmd_low_i) return `SFPM_CP_POSLOW;
        if (torque_limited_i) return `SFPM_CP_TQLIM;
        if (zero_speed_clamp_setting_i == `SFPM_CLAMP_ACTIVE && zero_speed_clamp_open_i)
            return `SFPM_CP_CLAMP;
        if (speed_cmd_low_i) return `SFPM_CP_SPDLOW;
        if (torque_cmd_low_i) return `SFPM_CP_TQLOW;
        if (bus_estop_i) return `SFPM_CP_BUSESTOP;
        return 4'h0;
    endfunction : exp_code

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        repeat (50000) @(posedge clk_i);
        n_mismatch = n_mismatch + 1;
        finish_test();
    end

    initial begin
        seed = 32'h102e_d573;
        {n_mismatch, n_compared, exp_st, exp_mt} = '0;
        views = '{`SFPM_V_POSDEV, `SFPM_V_SPEED, `SFPM_V_CTRL, `SFPM_V_IO, `SFPM_V_ERR,
            `SFPM_V_ST, `SFPM_V_MT, `SFPM_V_SERVO, `SFPM_V_ODIDX, `SFPM_V_ODVAL};
        {restart_i, param_wr_i, param_rd_i, enc_step_i, enc_ccw_i, half_toggle_i} = '0;
        {io_page_toggle_i, running_i, bus_undervolt_i, estop_i, positive_limit_open_i} = '0;
        {negative_limit_open_i, drive_alarm_i, relay_open_i, pos_cmd_low_i} = '0;
        {torque_limited_i, zero_speed_clamp_open_i, speed_cmd_low_i, torque_cmd_low_i} = '0;
        {bus_estop_i, param_index_i, param_wdata_i, motor_speed_i, error_record_i} = '0;
        {overtravel_setting_i, speed_cmd_i, zero_speed_clamp_setting_i, od_value_i} = '0;
        {digital_input_i, digital_output_i, pos_dev_i, control_mode_i, od_index_i} = '0;
        {fsm_state_i, bus_state_i, run_mode_i} = '0;
        servo_on_input_i = 1'b1;
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        param(1'b0, `SFPM_SEL_INDEX, 16'h0000);
        check(param_rdata_o, `SFPM_SEL_RESET);
        check(disp_o.view, `SFPM_V_SERVO);
        check(single_turn_o, 23'h00_0000);
        check(multiturn_o, 16'h0000);
        check(no_rotation_code_o, 4'h0);
        // wrap down through zero, back up, and down again so the turn count ends negative
        step(1'b0);
        step(1'b1);
        step(1'b0);
        for (i = 0; i < 40; i++) step(($random(seed) & 3) != 0);
        // out-of-range and foreign writes are dropped
        param(1'b1, `SFPM_SEL_INDEX, 16'h002B);
        param(1'b1, 16'h2529, 16'h0005);
        param(1'b0, `SFPM_SEL_INDEX, 16'h0000);
        check(param_rdata_o, `SFPM_SEL_RESET);
        param(1'b0, 16'h2529, 16'h0000);
        check(param_rdata_o, 16'h0000);
        for (k = 0; k < 10; k++) begin
            @(posedge clk_i);
            r = $random(seed);
            pos_dev_i <= $random(seed);
            {motor_speed_i, error_record_i} <= $random(seed);
            {control_mode_i, od_index_i} <= $random(seed);
            od_value_i <= $random(seed);
            {fsm_state_i, bus_state_i, run_mode_i, running_i} <= r[12:0];
            param(1'b1, `SFPM_SEL_INDEX, {10'h000, views[k]});
            repeat (3) @(posedge clk_i);
            #1;
            check(disp_o.view, (k == 0) ? `SFPM_V_SERVO : views[k - 1]);
            pulse(0);
            e = src(views[k]);
            check(disp_o.view, views[k]);
            check(disp_o.value, e[15:0]);
            e = neg(views[k]) ? `SFPM_DP_NEG : 10'h000;
            check(disp_o.dp, (views[k] == `SFPM_V_IO) ? `SFPM_DP_ALL : e[9:0]);
        end
        // high half of a negative deviation: both point pairs lit
        @(posedge clk_i);
        pos_dev_i <= 32'hFFFC_04EB;
        param(1'b1, `SFPM_SEL_INDEX, 16'h0000);
        pulse(0);
        check(disp_o.dp, 10'h000 | `SFPM_DP_NEG);
        pulse(1);
        check(disp_o.value, 16'h0003);
        check(disp_o.dp, `SFPM_DP_NEG | `SFPM_DP_HIGH);
        param(1'b1, `SFPM_SEL_INDEX, {10'h000, `SFPM_V_IO});
        pulse(0);
        for (i = 0; i < 24; i++) begin
            @(posedge clk_i);
            r = $random(seed);
            {digital_input_i, digital_output_i} <= r[19:0];
            if (i == 12) pulse(2);
            repeat (3) @(posedge clk_i);
            #1;
            e = (i < 12) ? digital_input_i : digital_output_i;
            check(disp_o.upper, e[9:0]);
            check(disp_o.lower, {22'h00_0000, ~e[9:0]});
            check(disp_o.dp, (i < 12) ? `SFPM_DP_ALL : 10'h000);
            check(io_ok, 1'b1);
        end
        for (i = 0; i < 300; i++) begin
            @(posedge clk_i);
            r = $random(seed) & $random(seed) & $random(seed);
            {bus_undervolt_i, positive_limit_open_i, negative_limit_open_i} <= r[2:0];
            {drive_alarm_i, relay_open_i, estop_i, pos_cmd_low_i} <= r[6:3];
            {torque_limited_i, zero_speed_clamp_open_i, speed_cmd_low_i} <= r[9:7];
            {torque_cmd_low_i, bus_estop_i} <= r[11:10];
            servo_on_input_i <= !r[12];
            overtravel_setting_i <= {15'h0000, r[13]};
            zero_speed_clamp_setting_i <= {15'h0000, r[14]};
            speed_cmd_i <= (i % 7 == 0) ? 16'h0000 : 16'($random(seed));
            repeat (2) @(posedge clk_i);
            #1;
            check(no_rotation_code_o, exp_code());
        end
        // the cause view shows the registered code of the last random pattern
        param(1'b1, `SFPM_SEL_INDEX, {10'h000, `SFPM_V_NOROT});
        pulse(0);
        check(disp_o.view, `SFPM_V_NOROT);
        check(disp_o.value, {12'h000, exp_code()});
        check(disp_o.dp, 10'h000);
        finish_test();
    end
endmodule : servo_front_panel_monitor_bench
